// file: sfdr_top.sv
// Start-of-frame delimiter matching and frame rate selection
// Behaviour
// (RULE_01) Matched delimiter picks the frame rate
// (RULE_02) Byte time 64/32/16/8/4 us per rate
// (RULE_03) Block bit drops 2 Mbps frames
// (RULE_04) Block bit drops 1 Mbps frames
// (RULE_05) Block bit drops 500 kbps frames
// (RULE_06) Block bit drops proprietary 250 kbps frames
// (RULE_07) Block bit drops standard 250 kbps frames
// (RULE_08) Block bit drops 125 kbps frames
// (RULE_09) Config bit chooses optimized or legacy scheme
// (RULE_10) Optimized 2 Mbps: pattern a,f exact
// (RULE_11) Optimized 1 Mbps: pattern b,g word
// (RULE_12) Optimized 1 Mbps tolerates two short bursts
// (RULE_13) 125 kbps word is pattern e,f
// (RULE_14) 500 kbps: pattern c, exact
// (RULE_15) 250 kbps: pattern d or fixed a7
// (RULE_16) Host keeps legacy patterns distinct, nonzero
// (RULE_17) Host keeps optimized a,b digits distinct
// (RULE_18) 125 kbps: three of four nibbles
// (RULE_19) 125 kbps timeout once preamble lost
// (RULE_20) 1 Mbps timeout when preamble octets lost
// (RULE_21) Legacy 2M/1M: single octets a,b exact
// (RULE_22) All rates compared in parallel, first wins
`timescale 1ns/1ps
module sfdr_top
	import sfdr_pkg::*;
#(
	parameter int BYTE_CYC_125K = sfdr_pkg::BYTE_US_125K * sfdr_pkg::CLK_MHZ,
	parameter int BYTE_CYC_250K = sfdr_pkg::BYTE_US_250K * sfdr_pkg::CLK_MHZ
) (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic nib_valid,
	input wire logic [3:0] nib_data,
	input wire logic oct_valid,
	input wire logic [7:0] oct_data,
	input wire logic frame_done,
	output logic delimiter_hit,
	output logic delimiter_timeout,
	output sfdr_pkg::sfdr_rate_t frame_rate,
	output logic rate_std_sfd,
	output logic rate_locked,
	output logic [6:0] byte_time_us,
	output logic byte_tick
);
	import sfdr_pkg::*;

	logic [7:0] cfg;
	logic [7:0] pat_a;
	logic [7:0] pat_b;
	logic [7:0] pat_c;
	logic [7:0] pat_d;
	logic [7:0] pat_e;
	logic [7:0] pat_f;
	logic [7:0] pat_g;

	sfdr_regs u_regs (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata),
		.rate_select_config(cfg),
		.delimiter_pattern_a(pat_a),
		.delimiter_pattern_b(pat_b),
		.delimiter_pattern_c(pat_c),
		.delimiter_pattern_d(pat_d),
		.delimiter_pattern_e(pat_e),
		.delimiter_pattern_f(pat_f),
		.delimiter_pattern_g(pat_g)
	);

	////////////////////////////////////////////////////////////////
	// Helpers

	function automatic logic [2:0] nib_agree(input logic [15:0] a, input logic [15:0] b);
		logic [2:0] n;
		n = 3'h0;
		for (int i = 0; i < 4; i++) begin
			if (a[4*i +: 4] == b[4*i +: 4]) begin
				n = n + 3'h1;
			end
		end
		return n;
	endfunction

	function automatic logic all_nonzero(input logic [19:0] h);
		logic r;
		r = 1'b1;
		for (int i = 0; i < 5; i++) begin
			if (h[4*i +: 4] == 4'h0) begin
				r = 1'b0;
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////
	// State

	sfdr_state_t state_r, state_nxt;
	sfdr_rate_t rate_r, rate_nxt;
	logic std_r, std_nxt;
	logic [23:0] oct_hist_r, oct_hist_nxt;
	logic [1:0] oct_cnt_r, oct_cnt_nxt;
	logic [19:0] nib_hist_r, nib_hist_nxt;
	logic [2:0] nib_cnt_r, nib_cnt_nxt;
	logic arm_1m_r, arm_1m_nxt;
	logic arm_125k_r, arm_125k_nxt;
	logic hit_r, hit_nxt;
	logic tmo_r, tmo_nxt;
	logic [6:0] us_r, us_nxt;
	logic [BYTE_CNT_W-1:0] bcyc_r, bcyc_nxt;
	logic [BYTE_CNT_W-1:0] bcnt_r, bcnt_nxt;
	logic tick_r, tick_nxt;

	////////////////////////////////////////////////////////////////
	// Parallel pattern compare

	logic opt;
	logic [23:0] oct_new;
	logic [19:0] nib_new;
	logic [15:0] word_1m;
	logic tol_1m;
	logic m_2m;
	logic m_1m;
	logic m_500k;
	logic m_250p;
	logic m_250s;
	logic m_125k;
	logic any_hit;
	logic t_1m;
	logic t_125k;

	assign oct_new = {oct_hist_r[15:0], oct_data};
	assign nib_new = {nib_hist_r[15:0], nib_data};
	assign word_1m = {pat_b, pat_g};

	sfdr_burst_match u_tol (
		.pattern(word_1m),
		.word(oct_new[15:0]),
		.tol_ok(tol_1m)
	);

	always_comb begin
		// (RULE_09) scheme select
		opt = cfg[BIT_OPTIMIZED];
		m_2m = 1'b0;
		m_1m = 1'b0;
		if (opt) begin
			// (RULE_10) 2 Mbps exact word
			m_2m = (oct_cnt_r != 2'h0) && (oct_new[15:0] == {pat_a, pat_f});
			// (RULE_11) 1 Mbps word compare
			m_1m = (oct_cnt_r != 2'h0) && tol_1m;
		end else begin
			// (RULE_21) legacy single octets
			m_2m = (oct_data == pat_a);
			m_1m = (oct_data == pat_b);
		end
		// (RULE_03) 2 Mbps gate
		m_2m = m_2m && oct_valid && !cfg[BIT_BLOCK_2M];
		// (RULE_04) 1 Mbps gate
		m_1m = m_1m && oct_valid && !cfg[BIT_BLOCK_1M];
		// (RULE_05) (RULE_14) 500 kbps exact
		m_500k = oct_valid && !cfg[BIT_BLOCK_500K] && (oct_data == pat_c);
		// (RULE_06) (RULE_15) proprietary 250 kbps
		m_250p = oct_valid && !cfg[BIT_BLOCK_250K_PROP] && (oct_data == pat_d);
		// (RULE_07) (RULE_15) standard 250 kbps
		m_250s = oct_valid && !cfg[BIT_BLOCK_250K_STD] && (oct_data == SFD_STD_250K);
		// (RULE_08) (RULE_13) (RULE_18) 125 kbps nibble vote
		m_125k = nib_valid && !cfg[BIT_BLOCK_125K] && (nib_cnt_r >= 3'h3)
			&& (nib_agree(nib_new[15:0], {pat_e, pat_f}) >= NIB_AGREE_MIN);
		any_hit = m_2m || m_1m || m_500k || m_250p || m_250s || m_125k;
		// (RULE_20) 1 Mbps preamble lost
		t_1m = opt && oct_valid && arm_1m_r && (oct_new != PRE_1M_SEQ) && !any_hit;
		// (RULE_19) 125 kbps preamble lost
		t_125k = nib_valid && arm_125k_r && all_nonzero(nib_new) && !any_hit;
	end

	////////////////////////////////////////////////////////////////
	// Search and lock sequencing

	always_comb begin
		state_nxt = state_r;
		rate_nxt = rate_r;
		std_nxt = std_r;
		oct_hist_nxt = oct_hist_r;
		oct_cnt_nxt = oct_cnt_r;
		nib_hist_nxt = nib_hist_r;
		nib_cnt_nxt = nib_cnt_r;
		arm_1m_nxt = arm_1m_r;
		arm_125k_nxt = arm_125k_r;
		hit_nxt = 1'b0;
		tmo_nxt = 1'b0;
		us_nxt = us_r;
		bcyc_nxt = bcyc_r;
		case (state_r)
			ST_SEARCH: begin
				if (oct_valid) begin
					oct_hist_nxt = oct_new;
					if (oct_cnt_r != OCT_HIST_FULL) begin
						oct_cnt_nxt = oct_cnt_r + 2'h1;
					end
					if (oct_new == PRE_1M_SEQ) begin
						arm_1m_nxt = 1'b1;
					end
				end
				if (nib_valid) begin
					nib_hist_nxt = nib_new;
					if (nib_cnt_r != NIB_HIST_FULL) begin
						nib_cnt_nxt = nib_cnt_r + 3'h1;
					end
					if ((nib_cnt_r >= 3'h4) && (nib_new == PRE_125K_NIBS)) begin
						arm_125k_nxt = 1'b1;
					end
				end
				// (RULE_22) fixed priority among same-cycle matches
				if (any_hit) begin
					hit_nxt = 1'b1;
					state_nxt = ST_LOCKED;
					std_nxt = 1'b0;
					// (RULE_01) rate from matched pattern
					// (RULE_02) byte time per rate
					if (m_2m) begin
						rate_nxt = RATE_2M;
						us_nxt = 7'(BYTE_US_2M);
						bcyc_nxt = BYTE_CNT_W'(BYTE_CYC_2M);
					end else if (m_1m) begin
						rate_nxt = RATE_1M;
						us_nxt = 7'(BYTE_US_1M);
						bcyc_nxt = BYTE_CNT_W'(BYTE_CYC_1M);
					end else if (m_500k) begin
						rate_nxt = RATE_500K;
						us_nxt = 7'(BYTE_US_500K);
						bcyc_nxt = BYTE_CNT_W'(BYTE_CYC_500K);
					end else if (m_250p || m_250s) begin
						rate_nxt = RATE_250K;
						std_nxt = !m_250p;
						us_nxt = 7'(BYTE_US_250K);
						bcyc_nxt = BYTE_CNT_W'(BYTE_CYC_250K);
					end else begin
						rate_nxt = RATE_125K;
						us_nxt = 7'(BYTE_US_125K);
						bcyc_nxt = BYTE_CNT_W'(BYTE_CYC_125K);
					end
				end else if (t_1m || t_125k) begin
					// Reception restarts from a clean history
					tmo_nxt = 1'b1;
					oct_hist_nxt = 24'h000000;
					oct_cnt_nxt = 2'h0;
					nib_hist_nxt = 20'h00000;
					nib_cnt_nxt = 3'h0;
					arm_1m_nxt = 1'b0;
					arm_125k_nxt = 1'b0;
				end
			end
			ST_LOCKED: begin
				if (frame_done) begin
					state_nxt = ST_SEARCH;
					rate_nxt = RATE_NONE;
					std_nxt = 1'b0;
					oct_hist_nxt = 24'h000000;
					oct_cnt_nxt = 2'h0;
					nib_hist_nxt = 20'h00000;
					nib_cnt_nxt = 3'h0;
					arm_1m_nxt = 1'b0;
					arm_125k_nxt = 1'b0;
				end
			end
			default: begin
				state_nxt = ST_SEARCH;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_r <= ST_SEARCH;
			rate_r <= RATE_NONE;
			std_r <= 1'b0;
			oct_hist_r <= 24'h000000;
			oct_cnt_r <= 2'h0;
			nib_hist_r <= 20'h00000;
			nib_cnt_r <= 3'h0;
			arm_1m_r <= 1'b0;
			arm_125k_r <= 1'b0;
			hit_r <= 1'b0;
			tmo_r <= 1'b0;
			us_r <= 7'h00;
			bcyc_r <= '0;
		end else begin
			state_r <= state_nxt;
			rate_r <= rate_nxt;
			std_r <= std_nxt;
			oct_hist_r <= oct_hist_nxt;
			oct_cnt_r <= oct_cnt_nxt;
			nib_hist_r <= nib_hist_nxt;
			nib_cnt_r <= nib_cnt_nxt;
			arm_1m_r <= arm_1m_nxt;
			arm_125k_r <= arm_125k_nxt;
			hit_r <= hit_nxt;
			tmo_r <= tmo_nxt;
			us_r <= us_nxt;
			bcyc_r <= bcyc_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Payload byte timer

	// (RULE_02) one tick per payload byte time
	always_comb begin
		bcnt_nxt = '0;
		tick_nxt = 1'b0;
		if (state_r == ST_LOCKED && !frame_done) begin
			if (bcnt_r == bcyc_r - BYTE_CNT_W'(1)) begin
				tick_nxt = 1'b1;
			end else begin
				bcnt_nxt = bcnt_r + BYTE_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			bcnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			bcnt_r <= bcnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign delimiter_hit = hit_r;
	assign delimiter_timeout = tmo_r;
	assign frame_rate = rate_r;
	assign rate_std_sfd = std_r;
	assign rate_locked = (state_r == ST_LOCKED);
	assign byte_time_us = us_r;
	assign byte_tick = tick_r;
endmodule

// file: sfdr_pkg.sv
// Constants and types shared by the delimiter rate recognition block
package sfdr_pkg;
	// Register offsets
	localparam logic [7:0] OFS_RATE_CFG = 8'h36;
	localparam logic [7:0] OFS_PAT_A = 8'h60;
	localparam logic [7:0] OFS_PAT_B = 8'h61;
	localparam logic [7:0] OFS_PAT_C = 8'h62;
	localparam logic [7:0] OFS_PAT_D = 8'h63;
	localparam logic [7:0] OFS_PAT_E = 8'h64;
	localparam logic [7:0] OFS_PAT_F = 8'h65;
	localparam logic [7:0] OFS_PAT_G = 8'h66;

	// Reset values
	localparam logic [7:0] RST_RATE_CFG = 8'h02;
	localparam logic [7:0] RST_PAT_A = 8'h00;
	localparam logic [7:0] RST_PAT_B = 8'h00;
	localparam logic [7:0] RST_PAT_C = 8'h3b;
	localparam logic [7:0] RST_PAT_D = 8'he5;
	localparam logic [7:0] RST_PAT_E = 8'h4d;
	localparam logic [7:0] RST_PAT_F = 8'ha8;
	localparam logic [7:0] RST_PAT_G = 8'hc8;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// Field positions in rate_select_config
	localparam int BIT_BLOCK_2M = 7;
	localparam int BIT_BLOCK_1M = 6;
	localparam int BIT_BLOCK_500K = 5;
	localparam int BIT_BLOCK_250K_PROP = 4;
	localparam int BIT_BLOCK_250K_STD = 3;
	localparam int BIT_BLOCK_125K = 2;
	localparam int BIT_OPTIMIZED = 1;

	// Fixed standard delimiter and preamble figures
	localparam logic [7:0] SFD_STD_250K = 8'ha7;
	localparam logic [23:0] PRE_1M_SEQ = 24'h0f0f0f;
	localparam logic [19:0] PRE_125K_NIBS = 20'h00000;
	localparam logic [2:0] NIB_AGREE_MIN = 3'h3;
	localparam logic [2:0] NIB_HIST_FULL = 3'h5;
	localparam logic [1:0] OCT_HIST_FULL = 2'h3;

	// Payload byte time per rate, in microseconds
	localparam int CLK_MHZ = 250;
	localparam int BYTE_US_125K = 64;
	localparam int BYTE_US_250K = 32;
	localparam int BYTE_US_500K = 16;
	localparam int BYTE_US_1M = 8;
	localparam int BYTE_US_2M = 4;
	localparam int BYTE_CYC_500K = BYTE_US_500K * CLK_MHZ;
	localparam int BYTE_CYC_1M = BYTE_US_1M * CLK_MHZ;
	localparam int BYTE_CYC_2M = BYTE_US_2M * CLK_MHZ;
	localparam int BYTE_CNT_W = 14;

	typedef enum logic [2:0] {
		RATE_NONE,
		RATE_125K,
		RATE_250K,
		RATE_500K,
		RATE_1M,
		RATE_2M
	} sfdr_rate_t;

	typedef enum logic {
		ST_SEARCH,
		ST_LOCKED
	} sfdr_state_t;
endpackage

// file: sfdr_regs.sv
// Host register file for rate configuration and delimiter patterns
`timescale 1ns/1ps
module sfdr_regs
	import sfdr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic [7:0] rate_select_config,
	output logic [7:0] delimiter_pattern_a,
	output logic [7:0] delimiter_pattern_b,
	output logic [7:0] delimiter_pattern_c,
	output logic [7:0] delimiter_pattern_d,
	output logic [7:0] delimiter_pattern_e,
	output logic [7:0] delimiter_pattern_f,
	output logic [7:0] delimiter_pattern_g
);
	logic [7:0] regs_r [0:7];
	logic [7:0] regs_nxt [0:7];
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [2:0] idx;
	logic hit;

	////////////////////////////////////////////////////////////////
	always_comb begin
		hit = 1'b1;
		idx = 3'h0;
		case (reg_addr)
			OFS_RATE_CFG: idx = 3'h0;
			OFS_PAT_A: idx = 3'h1;
			OFS_PAT_B: idx = 3'h2;
			OFS_PAT_C: idx = 3'h3;
			OFS_PAT_D: idx = 3'h4;
			OFS_PAT_E: idx = 3'h5;
			OFS_PAT_F: idx = 3'h6;
			OFS_PAT_G: idx = 3'h7;
			default: hit = 1'b0;
		endcase
		regs_nxt = regs_r;
		if (reg_wr_en && hit) begin
			regs_nxt[idx] = reg_wdata;
		end
		rdata_nxt = rdata_r;
		if (reg_rd_en) begin
			rdata_nxt = hit ? regs_r[idx] : RD_UNMAPPED;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			regs_r[0] <= RST_RATE_CFG;
			regs_r[1] <= RST_PAT_A;
			regs_r[2] <= RST_PAT_B;
			regs_r[3] <= RST_PAT_C;
			regs_r[4] <= RST_PAT_D;
			regs_r[5] <= RST_PAT_E;
			regs_r[6] <= RST_PAT_F;
			regs_r[7] <= RST_PAT_G;
			rdata_r <= RD_UNMAPPED;
		end else begin
			regs_r <= regs_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign rate_select_config = regs_r[0];
	assign delimiter_pattern_a = regs_r[1];
	assign delimiter_pattern_b = regs_r[2];
	assign delimiter_pattern_c = regs_r[3];
	assign delimiter_pattern_d = regs_r[4];
	assign delimiter_pattern_e = regs_r[5];
	assign delimiter_pattern_f = regs_r[6];
	assign delimiter_pattern_g = regs_r[7];
endmodule

// file: sfdr_burst_match.sv
// Tolerant 16-bit delimiter compare allowing up to two short error bursts
`timescale 1ns/1ps
module sfdr_burst_match (
	input wire logic [15:0] pattern,
	input wire logic [15:0] word,
	output logic tol_ok
);
	logic [15:0] diff;
	logic [4:0] starts;
	logic long_run;

	// (RULE_12) burst tolerant compare
	// Bit 15 and bit 0 count as neighbours, so end errors form one burst
	always_comb begin
		diff = pattern ^ word;
		starts = 5'h00;
		long_run = 1'b0;
		for (int i = 0; i < 16; i++) begin
			if (diff[i] && !diff[(i + 15) % 16]) begin
				starts = starts + 5'h01;
			end
			if (diff[i] && diff[(i + 1) % 16] && diff[(i + 2) % 16]) begin
				long_run = 1'b1;
			end
		end
		tol_ok = !long_run && (starts <= 5'h02);
	end
endmodule

// file: sfdr_props.sv
// Port checker for delimiter rate recognition
`timescale 1ns/1ps
module sfdr_props
	import sfdr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic frame_done,
	input wire logic delimiter_hit,
	input wire logic delimiter_timeout,
	input wire sfdr_pkg::sfdr_rate_t frame_rate,
	input wire logic rate_std_sfd,
	input wire logic rate_locked,
	input wire logic [6:0] byte_time_us,
	input wire logic byte_tick
);
	import sfdr_pkg::*;
	logic [7:0] cfg_r;
	logic [7:0] cfg_nxt;
	always_comb begin
		cfg_nxt = cfg_r;
		if (reg_wr_en && reg_addr == OFS_RATE_CFG) begin
			cfg_nxt = reg_wdata;
		end
	end
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_r <= RST_RATE_CFG;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end
	function automatic logic [6:0] bt(sfdr_rate_t r);
		case (r)
			RATE_125K: return 7'h40;
			RATE_250K: return 7'h20;
			RATE_500K: return 7'h10;
			RATE_1M: return 7'h08;
			default: return 7'h04;
		endcase
	endfunction
	// Std and proprietary 250k have separate block bits
	function automatic logic blk(logic [7:0] c, sfdr_rate_t r, logic s);
		case (r)
			RATE_2M: return c[7];
			RATE_1M: return c[6];
			RATE_500K: return c[5];
			RATE_250K: return s ? c[3] : c[4];
			RATE_125K: return c[2];
			default: return 1'b0;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	property p_hit_lock;
		delimiter_hit |-> rate_locked && frame_rate != RATE_NONE;
	endproperty
	a_hit_lock: assert property (p_hit_lock) else $error("hit without lock");
	property p_bt;
		rate_locked |-> byte_time_us == bt(frame_rate);
	endproperty
	a_bt: assert property (p_bt) else $error("byte time wrong");
	property p_blk;
		delimiter_hit |-> !blk($past(cfg_r), frame_rate, rate_std_sfd);
	endproperty
	a_blk: assert property (p_blk) else $error("blocked rate hit");
	property p_excl;
		delimiter_timeout |-> !delimiter_hit;
	endproperty
	a_excl: assert property (p_excl) else $error("hit with timeout");
	property p_ign;
		rate_locked |=> !delimiter_hit && !delimiter_timeout;
	endproperty
	a_ign: assert property (p_ign) else $error("event while locked");
	property p_done;
		rate_locked && frame_done |=> !rate_locked && frame_rate == RATE_NONE;
	endproperty
	a_done: assert property (p_done) else $error("lock not released");
	property p_std;
		rate_std_sfd |-> frame_rate == RATE_250K;
	endproperty
	a_std: assert property (p_std) else $error("std flag off 250k");
	property p_rd;
		reg_rd_en && reg_addr == OFS_RATE_CFG |=> reg_rdata == $past(cfg_r);
	endproperty
	a_rd: assert property (p_rd) else $error("config readback wrong");
	c_2m: cover property (delimiter_hit && frame_rate == RATE_2M);
	c_125: cover property (delimiter_hit && frame_rate == RATE_125K);
	c_to: cover property (delimiter_timeout);
endmodule
bind sfdr_top sfdr_props sfdr_props_i (.sys_clk, .arst_n, .reg_wr_en, .reg_rd_en, .reg_addr,
	.reg_wdata, .reg_rdata, .frame_done, .delimiter_hit, .delimiter_timeout, .frame_rate,
	.rate_std_sfd, .rate_locked, .byte_time_us, .byte_tick);

// file: sfdr_radio_model.sv
// Remote radio model feeding received octets and nibbles
`timescale 1ns/1ps
module sfdr_radio_model (
	input wire logic sys_clk,
	output logic nib_valid,
	output logic [3:0] nib_data,
	output logic oct_valid,
	output logic [7:0] oct_data
);
	initial begin
		nib_valid = 1'b0;
		nib_data = 4'h5;
		oct_valid = 1'b0;
		oct_data = 8'h5a;
	end
	// Idle data scrambled so a stale symbol never looks valid
	task automatic tx_oct(input logic [7:0] d);
		oct_data <= d;
		oct_valid <= 1'b1;
		@(posedge sys_clk);
		oct_valid <= 1'b0;
		oct_data <= 8'($urandom);
		repeat ($urandom_range(1, 3)) @(posedge sys_clk);
	endtask
	task automatic tx_nib(input logic [3:0] d);
		nib_data <= d;
		nib_valid <= 1'b1;
		@(posedge sys_clk);
		nib_valid <= 1'b0;
		nib_data <= 4'($urandom);
		repeat ($urandom_range(1, 3)) @(posedge sys_clk);
	endtask
endmodule

// file: tb.sv
// Self-checking bench for delimiter rate recognition
`timescale 1ns/1ps
module tb;
	import sfdr_pkg::*;
	localparam int C125 = 20;
	localparam int C250 = 10;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr_en = 1'b0;
	logic reg_rd_en = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic frame_done = 1'b0;
	logic [7:0] reg_rdata;
	logic nib_valid;
	logic [3:0] nib_data;
	logic oct_valid;
	logic [7:0] oct_data;
	logic delimiter_hit;
	logic delimiter_timeout;
	sfdr_rate_t frame_rate;
	logic rate_std_sfd;
	logic rate_locked;
	logic [6:0] byte_time_us;
	logic byte_tick;
	int fail_count = 0;
	int compares = 0;
	int cyc = 0;
	int hit_at = 0;
	int tick_at = 0;
	logic [3:0] seen = 4'h0;
	logic to_seen = 1'b0;
	// Shadow registers, written by wr, read by the rule model
	logic [7:0] rv [8] = '{8'h02, 8'h00, 8'h00, 8'h3b, 8'he5, 8'h4d, 8'ha8, 8'hc8};
	logic [7:0] oq [$];
	logic [3:0] nq [$];
	int m_res = 0;
	bit m_arm1 = 1'b0;
	bit m_arm125 = 1'b0;
	bit m_to = 1'b0;
	always #2 sys_clk = ~sys_clk;
	sfdr_top #(.BYTE_CYC_125K(C125), .BYTE_CYC_250K(C250)) sfdr_top_i (.sys_clk, .arst_n,
		.reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .nib_valid, .nib_data,
		.oct_valid, .oct_data, .frame_done, .delimiter_hit, .delimiter_timeout, .frame_rate,
		.rate_std_sfd, .rate_locked, .byte_time_us, .byte_tick);
	sfdr_radio_model sfdr_radio_model_i (.sys_clk, .nib_valid, .nib_data, .oct_valid,
		.oct_data);
	always @(posedge sys_clk) begin
		cyc++;
		if (delimiter_hit === 1'b1) begin
			hit_at = cyc;
			tick_at = 0;
			seen = {frame_rate, rate_std_sfd};
		end
		if (byte_tick === 1'b1 && tick_at == 0) begin
			tick_at = cyc;
		end
		if (delimiter_timeout === 1'b1) begin
			to_seen = 1'b1;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (fail_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk_reg(input logic [7:0] e, input logic [7:0] s);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH reg_rdata exp %h got %h", e, s);
		end
	endtask
	task automatic chk_res(input string n, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr_en <= 1'b0;
		if (a == OFS_RATE_CFG) begin
			rv[0] = d;
		end else if (a >= OFS_PAT_A && a <= OFS_PAT_G) begin
			rv[a - OFS_PAT_A + 8'h01] = d;
		end
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd_en <= 1'b0;
		@(posedge sys_clk);
		chk_reg(e, reg_rdata);
	endtask
	function automatic int us_of(logic [2:0] r);
		case (r)
			3'h1: return 64;
			3'h2: return 32;
			3'h3: return 16;
			3'h4: return 8;
			default: return 4;
		endcase
	endfunction
	////////////////////////////////////////////////////////////////
	// Rule model: m_res holds {rate, std flag} of the first hit until frame end
	// At most two runs of at most two bits, bit 15 next to bit 0
	function automatic bit tol_ok(input logic [15:0] x);
		int runs;
		bit ok;
		runs = 0;
		ok = 1'b1;
		for (int i = 0; i < 16; i++) begin
			if (x[i] && !x[(i + 15) % 16]) begin
				runs++;
			end
			if (x[i] && x[(i + 1) % 16] && x[(i + 2) % 16]) begin
				ok = 1'b0;
			end
		end
		return ok && runs <= 2;
	endfunction
	task automatic m_clear();
		oq.delete();
		nq.delete();
		m_arm1 = 1'b0;
		m_arm125 = 1'b0;
	endtask
	task automatic snd_oct(input logic [7:0] d);
		logic [7:0] c;
		logic [15:0] w;
		bit two;
		c = rv[0];
		two = oq.size() > 0;
		w = {two ? oq[$] : 8'h00, d};
		if (m_res == 0) begin
			oq.push_back(d);
			if (oq.size() > 3) begin
				void'(oq.pop_front());
			end
			if (!c[7] && (c[1] ? two && w == {rv[1], rv[6]} : d == rv[1])) begin
				m_res = {RATE_2M, 1'b0};
			end else if (!c[6] && (c[1] ? two && tol_ok(w ^ {rv[2], rv[7]}) : d == rv[2])) begin
				m_res = {RATE_1M, 1'b0};
			end else if (!c[5] && d == rv[3]) begin
				m_res = {RATE_500K, 1'b0};
			end else if (!c[4] && d == rv[4]) begin
				m_res = {RATE_250K, 1'b0};
			end else if (!c[3] && d == SFD_STD_250K) begin
				m_res = {RATE_250K, 1'b1};
			end else if (c[1] && m_arm1 && {oq[0], oq[1], oq[2]} != PRE_1M_SEQ) begin
				m_to = 1'b1;
				m_clear();
			end else if (oq.size() == 3 && {oq[0], oq[1], oq[2]} == PRE_1M_SEQ) begin
				m_arm1 = 1'b1;
			end
		end
		sfdr_radio_model_i.tx_oct(d);
	endtask
	task automatic snd_nib(input logic [3:0] d);
		logic [15:0] w;
		int n;
		bit z;
		bit nz;
		if (m_res == 0) begin
			nq.push_back(d);
			if (nq.size() > 5) begin
				void'(nq.pop_front());
			end
			w = {rv[5], rv[6]};
			n = 0;
			z = nq.size() == 5;
			nz = z;
			foreach (nq[k]) begin
				z = z && nq[k] == 4'h0;
				nz = nz && nq[k] != 4'h0;
			end
			for (int k = 0; k < 4 && nq.size() >= 4; k++) begin
				n += int'(nq[nq.size() - 4 + k] == w[15 - 4 * k -: 4]);
			end
			if (!rv[0][2] && n >= 3) begin
				m_res = {RATE_125K, 1'b0};
			end else if (m_arm125 && nz) begin
				m_to = 1'b1;
				m_clear();
			end else if (z) begin
				m_arm125 = 1'b1;
			end
		end
		sfdr_radio_model_i.tx_nib(d);
	endtask
	////////////////////////////////////////////////////////////////
	// Mode, config, symbols, expected rate and std flag
	logic [31:0] tv [21] = '{
		32'h002128ba, 32'h082128b0, 32'h00234c88, // words
		32'h00234cb8, 32'h00234dd0, 32'h002b4c98, // burst tolerance
		32'h04234c80, 32'h20200566, 32'h22200560, // singles
		32'h20200794, 32'h21200790, 32'h21200a75, // 250k cases
		32'h20a00a70, 32'h2000012a, 32'h20000348, // legacy
		32'h20000350, 32'h20200120, 32'h102ce8b2, // mode split
		32'h102c08b2, 32'h102c00b0, 32'h106ce8b0}; // nibbles
	initial begin
		logic [31:0] e;
		logic [2:0] r;
		void'($urandom(32'haaf2a1ea));
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		for (int i = 0; i < 8; i++) begin
			rd(i == 0 ? OFS_RATE_CFG : 8'(8'h5f + i), rv[i]); // reset values
		end
		wr(OFS_PAT_A, 8'h12);
		wr(OFS_PAT_B, 8'h34);
		wr(OFS_PAT_C, 8'h56);
		wr(OFS_PAT_D, 8'h79);
		wr(OFS_PAT_E, 8'hce);
		wr(OFS_PAT_F, 8'h8b);
		wr(8'h67, 8'($urandom));
		rd(8'h67, 8'h00); // unmapped reads zero
		rd(OFS_PAT_F, 8'h8b); // pattern kept
		for (int i = 0; i < 21; i++) begin
			e = tv[i];
			seen = 4'h0;
			wr(OFS_RATE_CFG, e[27:20]);
			if (e[31:28] == 4'h1) begin
				for (int k = 3; k >= 0; k--) begin
					snd_nib(e[4 + 4 * k +: 4]);
				end
			end else begin
				if (e[31:28] == 4'h0) begin
					snd_oct(e[19:12]);
				end
				snd_oct(e[11:4]);
			end
			repeat (3) @(posedge sys_clk);
			chk_res("rate", 16'(e[3:0]), 16'(seen)); // rate picked
			chk_res("model", 16'(m_res), 16'(seen)); // rule model
			if (seen != 4'h0) begin
				r = seen[3:1];
				for (int k = 0; k < 5000 && tick_at == 0; k++) @(posedge sys_clk);
				chk_res("us", 16'(us_of(r)), 16'(byte_time_us)); // byte time
				chk_res("tick", 16'(r == 3'h1 ? C125 : r == 3'h2 ? C250 : us_of(r) * 250),
					16'(tick_at - hit_at)); // tick spacing
				frame_done <= 1'b1;
				@(posedge sys_clk);
				frame_done <= 1'b0;
				@(posedge sys_clk);
				m_res = 0;
				m_clear();
			end
		end
		wr(OFS_RATE_CFG, 8'h02);
		to_seen = 1'b0;
		m_to = 1'b0;
		repeat (5) snd_nib(4'h0);
		repeat (4) snd_nib(4'h1);
		repeat (2) @(posedge sys_clk);
		chk_res("timeout", 16'h0, 16'(to_seen)); // four is not enough
		chk_res("model_to", 16'(m_to), 16'(to_seen)); // rule model
		snd_nib(4'h1);
		repeat (2) @(posedge sys_clk);
		chk_res("timeout", 16'h1, 16'(to_seen)); // preamble lost
		chk_res("model_to", 16'(m_to), 16'(to_seen)); // rule model
		to_seen = 1'b0;
		m_to = 1'b0;
		repeat (3) snd_oct(8'h0f);
		for (int k = 1; k < 4; k++) begin
			snd_oct(8'(k * 8'h11));
		end
		repeat (2) @(posedge sys_clk);
		chk_res("timeout", 16'h1, 16'(to_seen)); // octets lost
		chk_res("model_to", 16'(m_to), 16'(to_seen)); // rule model
		tally_and_finish();
	end
	// About twice the expected run, dominated by the unscaled 500 kbps, 1 Mbps and 2 Mbps byte timers
	initial begin
		#120000;
		fail_count++;
		tally_and_finish();
	end
endmodule
